// >>> src/sgr_pkg.sv
package sgr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] SGR_OFF_STATUS   = 4'h4;
  localparam logic [3:0] SGR_OFF_MODE     = 4'h5;
  localparam logic [3:0] SGR_OFF_CLOCK    = 4'h6;
  localparam logic [3:0] SGR_OFF_SECURITY = 4'h7;
  localparam int         SGR_ADDR_W       = 4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SGR_BIT_IRQ       = 6;
  localparam int SGR_BIT_DSR       = 0;
  localparam int SGR_BIT_CLKSW     = 7;
  localparam int SGR_BIT_ECHO      = 6;
  localparam int SGR_BIT_SYNC_RTS  = 5;
  localparam int SGR_BIT_SYNC_CTS  = 4;
  localparam int SGR_BIT_RLOOP     = 3;
  localparam int SGR_BIT_LLOOP     = 2;
  localparam int SGR_BIT_TSET_SRC  = 1;
  localparam int SGR_BIT_RXC_SRC   = 0;
  localparam logic [7:0] SGR_CLOCK_MASK = 8'h0f;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] SGR_RST_MODE     = 8'h00;
  localparam logic [7:0] SGR_RST_CLOCK    = 8'h00;
  localparam logic [7:0] SGR_RST_SECURITY = 8'hff;

  // ****************************************************************
  // Interface mode codes
  // ****************************************************************
  typedef enum logic [3:0] {
    SGR_MODE_OFF      = 4'h0,
    SGR_MODE_RS232    = 4'h2,
    SGR_MODE_RS485T   = 4'h4,
    SGR_MODE_RS485    = 4'h5,
    SGR_MODE_LOOP_SE  = 4'ha,
    SGR_MODE_LOOP_DIF = 4'hb,
    SGR_MODE_RS530    = 4'hd,
    SGR_MODE_V35      = 4'he,
    SGR_MODE_RS530A   = 4'hf
  } sgr_mode_t;

  // Line-side control bundle
  typedef struct packed {
    logic [3:0] interface_mode_code;
    logic       drivers_enable;
    logic       termination_enable;
    logic       echo_disable;
    logic       timing_clock_switch_enable;
    logic       remote_loop_bit;
    logic       local_loop_bit;
    logic       timing_out_source_select;
    logic       receive_clock_source_select;
  } sgr_line_ctrl_t;

endpackage : sgr_pkg

// >>> src/sgr_glue_regs.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sgr_glue_regs
  import sgr_pkg::*;
#(
  parameter logic [7:0] SECURITY_VALUE = SGR_RST_SECURITY
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [SGR_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [7:0]            avs_writedata_i,
  output logic      [7:0]            avs_readdata_o,
  output logic                       avs_waitrequest_o,
  input  wire logic                  ctrl_irq_n_i,
  input  wire logic                  set_ready_n_i,
  input  wire logic                  request_i,
  input  wire logic                  clear_i,
  output logic                       controller_sync_pin_o,
  output var sgr_line_ctrl_t         line_ctrl_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] irq_sync;
  logic [1:0] dsr_sync;
  logic [1:0] rts_sync;
  logic [1:0] cts_sync;

  // Interrupt line; resets to its quiet level so no false pending shows
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_sync <= 2'h3;
    end else begin
      irq_sync <= {irq_sync[0], ctrl_irq_n_i};
    end
  end

  // Set-ready line; only the second stage reaches the read mux
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dsr_sync <= 2'h3;
    end else begin
      dsr_sync <= {dsr_sync[0], set_ready_n_i};
    end
  end

  // Request line feeding the sync pin route
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rts_sync <= 2'h0;
    end else begin
      rts_sync <= {rts_sync[0], request_i};
    end
  end

  // Clear line feeding the sync pin route
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cts_sync <= 2'h0;
    end else begin
      cts_sync <= {cts_sync[0], clear_i};
    end
  end

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Idle waits for a request; the answer state is the one completing cycle
  typedef enum logic [1:0] {
    SGR_BUS_IDLE   = 2'b01,
    SGR_BUS_ANSWER = 2'b10
  } sgr_bus_state_t;

  sgr_bus_state_t bus_state;
  sgr_bus_state_t next_bus_state;
  logic           bus_request;
  logic           wr_take;
  logic           rd_take;

  assign bus_request = avs_read_i || avs_write_i;

  // Answer always falls back to idle, so a held request is never taken twice
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      SGR_BUS_IDLE:   next_bus_state = bus_request ? SGR_BUS_ANSWER : SGR_BUS_IDLE;
      SGR_BUS_ANSWER: next_bus_state = SGR_BUS_IDLE;
      default:        next_bus_state = SGR_BUS_IDLE;
    endcase
  end

  // Handshake state
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= SGR_BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Waitrequest is high while idle, low for the completing cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= (next_bus_state != SGR_BUS_ANSWER);
    end
  end

  // Write lands at the answer edge; read data is captured one edge earlier
  assign wr_take = avs_write_i && (bus_state == SGR_BUS_ANSWER);
  assign rd_take = avs_read_i && (bus_state == SGR_BUS_IDLE);

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0] mode_reg;
  logic [7:0] clock_reg;
  logic       wr_mode;
  logic       wr_clock;

  // One address compare shared by every write strobe
  function automatic logic reg_hit(input logic [SGR_ADDR_W-1:0] addr,
                                   input logic [SGR_ADDR_W-1:0] offset);
    reg_hit = (addr == offset);
  endfunction : reg_hit

  // Only two offsets take writes; status and security have no strobe
  assign wr_mode  = wr_take && reg_hit(avs_address_i, SGR_OFF_MODE);
  assign wr_clock = wr_take && reg_hit(avs_address_i, SGR_OFF_CLOCK);

  // Offset five keeps all eight bits as written
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= SGR_RST_MODE;
    end else if (wr_mode) begin
      mode_reg <= avs_writedata_i;
    end
  end

  // Upper nibble dropped on write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_reg <= SGR_RST_CLOCK;
    end else if (wr_clock) begin
      clock_reg <= avs_writedata_i & SGR_CLOCK_MASK;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [7:0] next_readdata;

  // Unmapped offsets in the 16-byte block read zero; status writes ignored
  always_comb begin
    next_readdata = 8'h00;
    unique case (avs_address_i)
      SGR_OFF_STATUS: begin
        next_readdata[SGR_BIT_IRQ] = irq_sync[1];
        next_readdata[SGR_BIT_DSR] = dsr_sync[1];
      end
      SGR_OFF_MODE:     next_readdata = mode_reg;
      SGR_OFF_CLOCK:    next_readdata = clock_reg;
      SGR_OFF_SECURITY: next_readdata = SECURITY_VALUE;
      default:          next_readdata = 8'h00;
    endcase
  end

  // Read data captured on the same cycle waitrequest falls
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 8'h00;
    end else if (rd_take) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // Only listed codes turn drivers on; others fall back to off
  function automatic logic mode_drives(input logic [3:0] code);
    unique case (code)
      SGR_MODE_RS232, SGR_MODE_RS485T, SGR_MODE_RS485,
      SGR_MODE_LOOP_SE, SGR_MODE_LOOP_DIF, SGR_MODE_RS530,
      SGR_MODE_V35, SGR_MODE_RS530A: mode_drives = 1'b1;
      default:                       mode_drives = 1'b0;
    endcase
  endfunction : mode_drives

  // Termination only for the balanced long-line modes
  function automatic logic mode_terminates(input logic [3:0] code);
    unique case (code)
      SGR_MODE_RS485T, SGR_MODE_RS530,
      SGR_MODE_V35, SGR_MODE_RS530A: mode_terminates = 1'b1;
      default:                       mode_terminates = 1'b0;
    endcase
  endfunction : mode_terminates

  // ****************************************************************
  // Line outputs
  // ****************************************************************
  logic [3:0] line_mode_code;
  logic       line_drivers;
  logic       line_termination;
  logic       line_echo_disable;
  logic       line_clock_switch;
  logic       line_remote_loop;
  logic       line_local_loop;
  logic       line_timing_source;
  logic       line_receive_source;

  // Flops only, no logic, so the transceiver never sees decode glitches
  assign line_ctrl_o = {line_mode_code, line_drivers, line_termination, line_echo_disable,
                        line_clock_switch, line_remote_loop, line_local_loop,
                        line_timing_source, line_receive_source};

  // Mode field handed on as written
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_mode_code <= 4'h0;
    end else begin
      line_mode_code <= mode_reg[3:0];
    end
  end

  // Drivers off for code 0 and every unsupported code
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_drivers <= 1'b0;
    end else begin
      line_drivers <= mode_drives(mode_reg[3:0]);
    end
  end

  // Termination for the balanced long-line modes only
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_termination <= 1'b0;
    end else begin
      line_termination <= mode_terminates(mode_reg[3:0]);
    end
  end

  // Echo control straight from offset five
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_echo_disable <= 1'b0;
    end else begin
      line_echo_disable <= mode_reg[SGR_BIT_ECHO];
    end
  end

  // Timing clock follows the transmit driver when set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_clock_switch <= 1'b0;
    end else begin
      line_clock_switch <= mode_reg[SGR_BIT_CLKSW];
    end
  end

  // Remote loop bit is stored and passed on; the transceiver acts on it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_remote_loop <= 1'b0;
    end else begin
      line_remote_loop <= clock_reg[SGR_BIT_RLOOP];
    end
  end

  // Local loop bit, likewise
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_local_loop <= 1'b0;
    end else begin
      line_local_loop <= clock_reg[SGR_BIT_LLOOP];
    end
  end

  // Timing output source pick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_timing_source <= 1'b0;
    end else begin
      line_timing_source <= clock_reg[SGR_BIT_TSET_SRC];
    end
  end

  // Receive clock source pick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_receive_source <= 1'b0;
    end else begin
      line_receive_source <= clock_reg[SGR_BIT_RXC_SRC];
    end
  end

  // ****************************************************************
  // Sync pin routing
  // ****************************************************************
  logic next_sync_pin;

  // Unrouted pin idles high; both bits set make it the AND of the two lines
  always_comb begin
    next_sync_pin = 1'b1;
    if (mode_reg[SGR_BIT_SYNC_RTS]) begin
      next_sync_pin = next_sync_pin & rts_sync[1];
    end
    if (mode_reg[SGR_BIT_SYNC_CTS]) begin
      next_sync_pin = next_sync_pin & cts_sync[1];
    end
  end

  // Registered so a route change cannot glitch the controller's sync input
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      controller_sync_pin_o <= 1'b1;
    end else begin
      controller_sync_pin_o <= next_sync_pin;
    end
  end

endmodule : sgr_glue_regs

`default_nettype wire

// >>> verif/sgr_glue_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sgr_glue_monitor
  import sgr_pkg::*;
#(parameter logic [7:0] SECURITY_VALUE = SGR_RST_SECURITY) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] avs_address_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  input wire logic [7:0] avs_readdata_o,
  input wire logic       avs_waitrequest_o,
  input wire logic       controller_sync_pin_o,
  input wire sgr_line_ctrl_t line_ctrl_o
);
  // Write data two edges back, for the one-cycle output lag
  logic [7:0] wd1, wd2;
  always_ff @(posedge core_clk_i) {wd2, wd1} <= {wd1, avs_writedata_i};
  wire logic       rd_ack = avs_read_i && !avs_waitrequest_o;
  wire logic       wr_ack = avs_write_i && !avs_waitrequest_o;
  wire logic [3:0] ad     = avs_address_i;
  wire logic [3:0] lm     = line_ctrl_o.interface_mode_code;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_WAIT_ONE: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("wait not one cycle");
  AST_UNMAPPED: assert property (rd_ack && (ad < 4'h4 || ad > 4'h7) |-> avs_readdata_o == 8'h00) else $error("unmapped read");
  AST_STAT_ZERO: assert property (rd_ack && ad == SGR_OFF_STATUS |-> !avs_readdata_o[7] && avs_readdata_o[5:1] == 5'h0) else $error("status zeros");
  AST_CLK_HI: assert property (rd_ack && ad == SGR_OFF_CLOCK |-> avs_readdata_o[7:4] == 4'h0) else $error("clock upper");
  AST_SECURITY: assert property (rd_ack && ad == SGR_OFF_SECURITY |-> avs_readdata_o == SECURITY_VALUE) else $error("security");
  AST_MODE_WR: assert property (wr_ack && ad == SGR_OFF_MODE |=> ##1 {lm, line_ctrl_o.echo_disable, line_ctrl_o.timing_clock_switch_enable} == {wd2[3:0], wd2[6], wd2[7]}) else $error("mode write");
  AST_CLK_WR: assert property (wr_ack && ad == SGR_OFF_CLOCK |=> ##1 {line_ctrl_o.timing_out_source_select, line_ctrl_o.receive_clock_source_select} == wd2[1:0]) else $error("clock write");
  AST_TERM: assert property (line_ctrl_o.termination_enable == (lm inside {SGR_MODE_RS485T, SGR_MODE_RS530, SGR_MODE_V35, SGR_MODE_RS530A})) else $error("termination");
  AST_DRIVE: assert property (line_ctrl_o.drivers_enable == (lm inside {4'h2, 4'h4, 4'h5, 4'ha, 4'hb, 4'hd, 4'he, 4'hf})) else $error("drivers");
  AST_SYNC_HIGH: assert property (wr_ack && ad == SGR_OFF_MODE && avs_writedata_i[5:4] == 2'b00 |=> ##1 controller_sync_pin_o) else $error("sync high");
endmodule : sgr_glue_monitor
bind sgr_glue_regs sgr_glue_monitor #(.SECURITY_VALUE(SECURITY_VALUE)) sgr_glue_monitor_i (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .controller_sync_pin_o(controller_sync_pin_o), .line_ctrl_o(line_ctrl_o));
`default_nettype wire

// >>> verif/sgr_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module sgr_line_model (
  input wire logic       core_clk_i,
  input wire logic [3:0] level_i,
  output logic           ctrl_irq_n_o = 1'b1,
  output logic           set_ready_n_o = 1'b1,
  output logic           request_o = 1'b1,
  output logic           clear_o = 1'b1
);
  // Lines move only after an edge; design must still synchronise them
  always @(posedge core_clk_i) {ctrl_irq_n_o, set_ready_n_o, request_o, clear_o} <= level_i;
endmodule : sgr_line_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sgr_pkg::*;
  logic           core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0]     avs_address_i = 4'h0, line_lv = 4'hf;
  logic [7:0]     avs_writedata_i = 8'h00, avs_readdata_o, d;
  logic [11:0]    rd, ex;
  logic           avs_waitrequest_o, controller_sync_pin_o, irq_n, dsr_n, req, clr, p;
  sgr_line_ctrl_t line_ctrl_o;
  int             err_count = 0, comparisons = 0, i;
  always #5 core_clk_i = ~core_clk_i;
  sgr_glue_regs sgr_glue_regs_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ctrl_irq_n_i(irq_n), .set_ready_n_i(dsr_n),
    .request_i(req), .clear_i(clr), .controller_sync_pin_o(controller_sync_pin_o),
    .line_ctrl_o(line_ctrl_o));
  sgr_line_model sgr_line_model_i (.core_clk_i(core_clk_i), .level_i(line_lv),
    .ctrl_irq_n_o(irq_n), .set_ready_n_o(dsr_n), .request_o(req), .clear_o(clr));
  // ****
  // Shared tasks
  // ****
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Avalon master: holds request until a rising edge sees waitrequest low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 20) begin
      err_count++;
      $display("ERROR %0t bus wait timed out", $time);
    end
    rd = {4'h0, avs_readdata_o};
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task set_lines(input logic [3:0] lv);
    @(posedge core_clk_i);
    line_lv <= lv;
    repeat (6) @(negedge core_clk_i); // Past both synchroniser stages
  endtask : set_lines
  // ****
  // Scenarios
  // ****
  task t_reset;
    @(negedge core_clk_i);
    chk(line_ctrl_o, 12'h000);
    chk({11'h0, controller_sync_pin_o}, 12'h001);
    chk({11'h0, avs_waitrequest_o}, 12'h001);
    bus(0, SGR_OFF_MODE, 8'h00); chk(rd, 12'h000);
    bus(0, SGR_OFF_CLOCK, 8'h00); chk(rd, 12'h000);
    bus(1, SGR_OFF_SECURITY, 8'h00);
    bus(0, SGR_OFF_SECURITY, 8'h00); chk(rd, 12'h0ff);
  endtask : t_reset
  task t_status;
    for (i = 0; i < 4; i++) begin
      set_lines({i[1:0], 2'b11});
      ex = {5'h0, i[1], 5'h0, i[0]};
      bus(0, SGR_OFF_STATUS, 8'h00); chk(rd, ex);
      bus(1, SGR_OFF_STATUS, 8'hff);
      bus(0, SGR_OFF_STATUS, 8'h00); chk(rd, ex);
    end
  endtask : t_status
  // Every mode code, back-to-back write then read
  task t_modes;
    for (i = 0; i < 16; i++) begin
      d = {~i[3:0], i[3:0]};
      bus(1, SGR_OFF_MODE, d);
      bus(0, SGR_OFF_MODE, 8'h00); chk(rd, {4'h0, d});
      ex = {i[3:0], (d[3:0] inside {4'h2, 4'h4, 4'h5, 4'ha, 4'hb, 4'hd, 4'he, 4'hf}),
            (d[3:0] inside {4'h4, 4'hd, 4'he, 4'hf}), d[6], d[7], 4'h0};
      chk(line_ctrl_o, ex);
    end
  endtask : t_modes
  task t_clock;
    for (i = 0; i < 2; i++) begin
      d = i[0] ? 8'hf5 : 8'h0a;
      bus(1, SGR_OFF_CLOCK, d);
      bus(0, SGR_OFF_CLOCK, 8'h00); chk(rd, {8'h0, d[3:0]});
      chk({8'h0, line_ctrl_o[3:0]}, {8'h0, d[3:0]});
    end
  endtask : t_clock
  // Sync pin routing over all route bits and line levels
  task t_sync;
    for (i = 0; i < 16; i++) begin
      bus(1, SGR_OFF_MODE, {2'b00, i[3:2], 4'h2});
      set_lines({2'b11, i[1:0]});
      p = (i[3] ? i[1] : 1'b1) & (i[2] ? i[0] : 1'b1);
      chk({11'h0, controller_sync_pin_o}, {11'h0, p});
    end
  endtask : t_sync
  task t_unmapped;
    for (i = 0; i < 16; i++) begin
      if (i < 4 || i > 7) begin
        bus(1, i[3:0], 8'h3c);
        bus(0, i[3:0], 8'h00); chk(rd, 12'h000);
      end
    end
    bus(0, SGR_OFF_MODE, 8'h00); chk(rd, 12'h032);
  endtask : t_unmapped
  // Reset in mid-run returns every control to its idle value
  task t_midreset;
    bus(1, SGR_OFF_MODE, 8'hff);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(negedge core_clk_i);
    chk(line_ctrl_o, 12'h000);
    chk({11'h0, controller_sync_pin_o}, 12'h001);
    bus(0, SGR_OFF_MODE, 8'h00); chk(rd, 12'h000);
    bus(0, SGR_OFF_CLOCK, 8'h00); chk(rd, 12'h000);
  endtask : t_midreset
  task results;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset; t_status; t_modes; t_clock; t_sync; t_unmapped; t_midreset;
    results;
  end
  // Watchdog, about forty times the expected run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    results;
  end
endmodule : testbench
`default_nettype wire
